/* File: camera_mode_sequencer.v */
// camera mode sequencer: driver enables, program requests, phase machine and
// shared tuning variables with low-light parameter interpolation
// assumes all inputs come from logic on sys_clk_i; frame_start_i is a one-cycle pulse
`timescale 1ns/100ps
`include "camera_mode_sequencer_consts.vh"

module camera_mode_sequencer (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // variable access
  input wire [4:0] var_addr_i,
  input wire var_wr_i,
  input wire [7:0] var_wdata_i,
  output reg [7:0] var_rdata_o,
  // frame timing and driver status
  input wire frame_start_i,
  input wire drivers_settled_i,
  input wire exposure_fast_i,
  input wire balance_fast_i,
  input wire [1:0] flash_mode_i,
  // measurements
  input wire [7:0] exposure_value_i,
  input wire [7:0] exposure_virtual_gain_i,
  input wire [7:0] digital_gain_one_i,
  input wire [7:0] digital_gain_two_i,
  // driver control
  output reg [4:0] driver_enable_o,
  output reg driver_timeout_o,
  output reg refresh_o,
  output reg [3:0] phase_o,
  output reg [7:0] exposure_weight_o,
  output reg [7:0] exposure_steps_o,
  output reg exposure_average_o,
  output reg [7:0] balance_weight_o,
  output reg [7:0] balance_steps_o,
  output reg balance_average_o,
  output reg force_daylight_o,
  output reg flash_fire_o,
  output reg [1:0] flash_kind_o,
  // low-light results
  output reg [9:0] virtual_gain_o,
  output reg [7:0] saturation_o,
  output reg [7:0] interp_threshold_o,
  output reg reduce_aperture_o,
  output reg raise_aperture_thresh_o,
  output reg luma_filter_o
);

  reg [7:0] drv_en_r;
  reg [7:0] prog_r;
  reg [3:0] phase_r;
  reg [3:0] phase_nxt;
  reg [7:0] step_r;
  reg [7:0] strobe_r;
  reg [7:0] exp_slow_w_r;
  reg [7:0] exp_slow_s_r;
  reg [7:0] exp_quick_w_r;
  reg [7:0] exp_quick_s_r;
  reg [7:0] bal_slow_w_r;
  reg [7:0] bal_slow_s_r;
  reg [7:0] bal_quick_w_r;
  reg [7:0] bal_quick_s_r;
  reg [7:0] timeout_r;
  reg [7:0] strobe_lim_r;
  reg [7:0] day_lim_r;
  reg [7:0] dim_opt_r;
  reg [7:0] gain_lo_r;
  reg [7:0] gain_hi_r;
  reg [7:0] sat_hi_r;
  reg [7:0] sat_lo_r;
  reg [7:0] interp_lo_r;
  reg [7:0] interp_hi_r;
  reg [7:0] frame_cnt_r;
  reg [3:0] mode_target_r;
  localparam [15:0] method_ptr = `RST_METHOD_PTR;

  wire steady;
  wire take_prog;
  wire timed_out;
  wire step_on;
  wire step_go;
  wire advance;
  wire consume_step;
  wire flash_now;
  wire wr_prog;
  wire wr_step;
  wire wr_strobe;
  wire [9:0] vgain;

  assign steady = (phase_r == `PH_PREVIEW) || (phase_r == `PH_CAPTURE) ||
                  (phase_r == `PH_STANDBY) || (phase_r == `PH_INIT);
  // programs are accepted only in a resting phase so a transition is never cut short
  assign take_prog = steady && (prog_r != `PRG_RUN);
  assign timed_out = (frame_cnt_r >= timeout_r);
  assign step_on = step_r[`STEP_ON_BIT];
  assign step_go = step_r[`STEP_GO_BIT];
  // with stepping off, transitional phases move on a frame once drivers settle or time out; with it on, on the go bit
  assign advance = step_on ? step_go : (frame_start_i && (drivers_settled_i || timed_out));
  assign consume_step = step_on && step_go && !steady;
  assign wr_prog = var_wr_i && (var_addr_i == `OFS_PROGRAM_REQ);
  assign wr_step = var_wr_i && (var_addr_i == `OFS_STEP_CTRL);
  assign wr_strobe = var_wr_i && (var_addr_i == `OFS_STROBE_KIND);
  // auto mode fires below threshold; locked keeps the lock-time decision
  assign flash_now = (flash_mode_i == `FLASH_ON) ||
                     ((flash_mode_i == `FLASH_AUTO) && (exposure_value_i < strobe_lim_r)) ||
                     ((flash_mode_i == `FLASH_LOCKED) && strobe_r[`STROBE_LOCK_BIT]);
  // truncating shifts; the sum fits in ten bits
  assign vgain = {3'h0, exposure_virtual_gain_i[7:1]} + {6'h00, digital_gain_one_i[7:4]} +
                 {4'h0, digital_gain_two_i[7:2]};

  // plain writable tuning variables
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      drv_en_r <= `RST_DRIVER_ENABLE;
      exp_slow_w_r <= `RST_SLOW_WEIGHT;
      exp_slow_s_r <= `RST_SLOW_STEPS;
      exp_quick_w_r <= `RST_QUICK_WEIGHT;
      exp_quick_s_r <= `RST_QUICK_STEPS;
      bal_slow_w_r <= `RST_SLOW_WEIGHT;
      bal_slow_s_r <= `RST_SLOW_STEPS;
      bal_quick_w_r <= `RST_QUICK_WEIGHT;
      bal_quick_s_r <= `RST_QUICK_STEPS;
      timeout_r <= `RST_FRAME_TIMEOUT;
      strobe_lim_r <= `RST_STROBE_LIMIT;
      day_lim_r <= `RST_DAYLIGHT_LIMIT;
      dim_opt_r <= `RST_DIM_OPTIONS;
      gain_lo_r <= `RST_DIM_GAIN_LOWER;
      gain_hi_r <= `RST_DIM_GAIN_UPPER;
      sat_hi_r <= `RST_SAT_UPPER;
      sat_lo_r <= `RST_SAT_LOWER;
      interp_lo_r <= `RST_INTERP_LOWER;
      interp_hi_r <= `RST_INTERP_UPPER;
    end else if (var_wr_i) begin
      case (var_addr_i)
        `OFS_DRIVER_ENABLE: drv_en_r <= var_wdata_i;
        `OFS_EXP_SLOW_WEIGHT: exp_slow_w_r <= var_wdata_i;
        `OFS_EXP_SLOW_STEPS: exp_slow_s_r <= var_wdata_i;
        `OFS_EXP_QUICK_WEIGHT: exp_quick_w_r <= var_wdata_i;
        `OFS_EXP_QUICK_STEPS: exp_quick_s_r <= var_wdata_i;
        `OFS_BAL_SLOW_WEIGHT: bal_slow_w_r <= var_wdata_i;
        `OFS_BAL_SLOW_STEPS: bal_slow_s_r <= var_wdata_i;
        `OFS_BAL_QUICK_WEIGHT: bal_quick_w_r <= var_wdata_i;
        `OFS_BAL_QUICK_STEPS: bal_quick_s_r <= var_wdata_i;
        `OFS_FRAME_TIMEOUT: timeout_r <= var_wdata_i;
        `OFS_STROBE_LIMIT: strobe_lim_r <= var_wdata_i;
        `OFS_DAYLIGHT_LIMIT: day_lim_r <= var_wdata_i;
        `OFS_DIM_OPTIONS: dim_opt_r <= var_wdata_i;
        `OFS_DIM_GAIN_LOWER: gain_lo_r <= var_wdata_i;
        `OFS_DIM_GAIN_UPPER: gain_hi_r <= var_wdata_i;
        `OFS_SAT_UPPER: sat_hi_r <= var_wdata_i;
        `OFS_SAT_LOWER: sat_lo_r <= var_wdata_i;
        `OFS_INTERP_LOWER: interp_lo_r <= var_wdata_i;
        `OFS_INTERP_UPPER: interp_hi_r <= var_wdata_i;
        default: ;
      endcase
    end
  end

  // program byte: a write in the same cycle as the take is kept, not lost
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      prog_r <= `RST_PROGRAM_REQ;
    end else if (wr_prog) begin
      prog_r <= var_wdata_i;
    end else if (take_prog) begin
      prog_r <= `PRG_RUN;
    end
  end

  // step control: the go bit clears itself once a step is made
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      step_r <= `RST_STEP_CTRL;
    end else if (wr_step) begin
      step_r <= var_wdata_i;
    end else if (consume_step) begin
      step_r[`STEP_GO_BIT] <= 1'b0;
    end
  end

  // strobe kind: lock sets bit 7 even against a write in the same cycle
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      strobe_r <= `RST_STROBE_KIND;
    end else begin
      if (wr_strobe) begin
        strobe_r <= var_wdata_i;
      end
      if (take_prog && (prog_r == `PRG_LOCK) && flash_now) begin
        strobe_r[`STROBE_LOCK_BIT] <= 1'b1;
      end
    end
  end

  // phase machine
  always @* begin
    phase_nxt = phase_r;
    if (take_prog) begin
      case (prog_r)
        `PRG_PREVIEW: phase_nxt = (phase_r == `PH_PREVIEW) ? `PH_PREVIEW : `PH_TO_PREVIEW;
        `PRG_CAPTURE: phase_nxt = (phase_r == `PH_PREVIEW) ? `PH_LEAVE_PREVIEW : `PH_TO_CAPTURE;
        `PRG_STANDBY: phase_nxt = (phase_r == `PH_PREVIEW) ? `PH_LEAVE_PREVIEW :
                                  (phase_r == `PH_CAPTURE) ? `PH_LEAVE_CAPTURE : `PH_STANDBY;
        `PRG_REFRESH_MODE: phase_nxt = (phase_r == `PH_CAPTURE) ? `PH_TO_CAPTURE : `PH_TO_PREVIEW;
        default: phase_nxt = phase_r; // lock and refresh leave the phase alone
      endcase
    end else if (advance) begin
      case (phase_r)
        `PH_TO_PREVIEW: phase_nxt = `PH_ENTER_PREVIEW;
        `PH_ENTER_PREVIEW: phase_nxt = `PH_PREVIEW;
        `PH_LEAVE_PREVIEW: phase_nxt = (mode_target_r == `PH_STANDBY) ? `PH_STANDBY : `PH_TO_CAPTURE;
        `PH_TO_CAPTURE: phase_nxt = `PH_ENTER_CAPTURE;
        `PH_ENTER_CAPTURE: phase_nxt = `PH_CAPTURE;
        `PH_LEAVE_CAPTURE: phase_nxt = (mode_target_r == `PH_STANDBY) ? `PH_STANDBY : `PH_TO_PREVIEW;
        default: phase_nxt = phase_r;
      endcase
    end
  end

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      phase_r <= `PH_PREVIEW;
      mode_target_r <= `PH_PREVIEW;
      frame_cnt_r <= 8'h00;
    end else begin
      phase_r <= phase_nxt;
      if (take_prog && (prog_r == `PRG_STANDBY)) begin
        mode_target_r <= `PH_STANDBY;
      end else if (take_prog && (prog_r == `PRG_CAPTURE)) begin
        mode_target_r <= `PH_CAPTURE;
      end else if (take_prog && (prog_r == `PRG_PREVIEW)) begin
        mode_target_r <= `PH_PREVIEW;
      end
      // frames are counted per phase so every transition gets its own timeout budget
      if (phase_nxt != phase_r) begin
        frame_cnt_r <= 8'h00;
      end else if (frame_start_i && (frame_cnt_r != 8'hFF)) begin
        frame_cnt_r <= frame_cnt_r + 8'h01;
      end
    end
  end

  // driver-facing settings
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      driver_enable_o <= 5'h00;
      driver_timeout_o <= 1'b0;
      refresh_o <= 1'b0;
      phase_o <= `PH_PREVIEW;
      exposure_weight_o <= 8'h00;
      exposure_steps_o <= 8'h00;
      exposure_average_o <= 1'b0;
      balance_weight_o <= 8'h00;
      balance_steps_o <= 8'h00;
      balance_average_o <= 1'b0;
      force_daylight_o <= 1'b0;
      flash_fire_o <= 1'b0;
      flash_kind_o <= 2'h0;
    end else begin
      driver_enable_o <= drv_en_r[4:0];
      driver_timeout_o <= timed_out && !steady;
      refresh_o <= take_prog && (prog_r == `PRG_REFRESH);
      phase_o <= phase_r;
      exposure_weight_o <= exposure_fast_i ? exp_quick_w_r : exp_slow_w_r;
      exposure_steps_o <= exposure_fast_i ? exp_quick_s_r : exp_slow_s_r;
      exposure_average_o <= (exposure_fast_i ? exp_quick_w_r : exp_slow_w_r) < `WEIGHT_NO_AVERAGE;
      balance_weight_o <= balance_fast_i ? bal_quick_w_r : bal_slow_w_r;
      balance_steps_o <= balance_fast_i ? bal_quick_s_r : bal_slow_s_r;
      balance_average_o <= (balance_fast_i ? bal_quick_w_r : bal_slow_w_r) < `WEIGHT_NO_AVERAGE;
      force_daylight_o <= drv_en_r[`OUTDOOR_BIT] && (exposure_value_i > day_lim_r);
      flash_fire_o <= flash_now && (strobe_r[1:0] != 2'h0);
      flash_kind_o <= strobe_r[1:0];
    end
  end

  // low-light interpolation; the divide is combinational, traded for area against latency
  reg [7:0] span;
  reg [7:0] pos;
  reg [15:0] sat_prod;
  reg [15:0] int_prod;
  reg [7:0] sat_calc;
  reg [7:0] int_calc;
  reg [7:0] sat_min;
  reg [7:0] sat_max;
  reg [7:0] int_min;
  reg [7:0] int_max;

  always @* begin
    span = 8'h00;
    pos = 8'h00;
    sat_prod = 16'h0000;
    int_prod = 16'h0000;
    sat_min = (sat_lo_r < sat_hi_r) ? sat_lo_r : sat_hi_r;
    sat_max = (sat_lo_r < sat_hi_r) ? sat_hi_r : sat_lo_r;
    int_min = (interp_lo_r < interp_hi_r) ? interp_lo_r : interp_hi_r;
    int_max = (interp_lo_r < interp_hi_r) ? interp_hi_r : interp_lo_r;
    if (gain_hi_r > gain_lo_r) begin
      span = gain_hi_r - gain_lo_r;
    end
    // adjustment starts at the lower gain and ends at the upper
    if (vgain <= {2'h0, gain_lo_r}) begin
      pos = 8'h00;
    end else if (vgain >= {2'h0, gain_hi_r}) begin
      pos = span;
    end else begin
      pos = vgain[7:0] - gain_lo_r;
    end
    if (span != 8'h00) begin
      sat_prod = ((sat_max - sat_min) * pos) / span;
      int_prod = ((int_max - int_min) * pos) / span;
    end
    // saturation falls as gain rises; interpolation threshold rises
    sat_calc = dim_opt_r[`DIM_SAT_BIT] ? (sat_max - sat_prod[7:0]) : sat_max;
    int_calc = dim_opt_r[`DIM_INTERP_BIT] ? (int_min + int_prod[7:0]) : int_min;
  end

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      virtual_gain_o <= 10'h000;
      saturation_o <= `RST_SAT_UPPER;
      interp_threshold_o <= `RST_INTERP_LOWER;
      reduce_aperture_o <= 1'b0;
      raise_aperture_thresh_o <= 1'b0;
      luma_filter_o <= 1'b0;
    end else begin
      virtual_gain_o <= vgain;
      saturation_o <= (sat_calc < sat_min) ? sat_min : (sat_calc > sat_max) ? sat_max : sat_calc;
      interp_threshold_o <= (int_calc < int_min) ? int_min : (int_calc > int_max) ? int_max : int_calc;
      reduce_aperture_o <= dim_opt_r[`DIM_APCORR_BIT];
      raise_aperture_thresh_o <= dim_opt_r[`DIM_APTHRESH_BIT];
      luma_filter_o <= dim_opt_r[`DIM_YFILT_BIT];
    end
  end

  // read data, registered; unmapped offsets read zero
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      var_rdata_o <= 8'h00;
    end else begin
      case (var_addr_i)
        `OFS_METHOD_PTR_HI: var_rdata_o <= method_ptr[15:8];
        `OFS_METHOD_PTR_LO: var_rdata_o <= method_ptr[7:0];
        `OFS_DRIVER_ENABLE: var_rdata_o <= drv_en_r;
        `OFS_PROGRAM_REQ: var_rdata_o <= prog_r;
        `OFS_CURRENT_PHASE: var_rdata_o <= {4'h0, phase_r};
        `OFS_STEP_CTRL: var_rdata_o <= step_r;
        `OFS_STROBE_KIND: var_rdata_o <= strobe_r;
        `OFS_EXP_SLOW_WEIGHT: var_rdata_o <= exp_slow_w_r;
        `OFS_EXP_SLOW_STEPS: var_rdata_o <= exp_slow_s_r;
        `OFS_EXP_QUICK_WEIGHT: var_rdata_o <= exp_quick_w_r;
        `OFS_EXP_QUICK_STEPS: var_rdata_o <= exp_quick_s_r;
        `OFS_BAL_SLOW_WEIGHT: var_rdata_o <= bal_slow_w_r;
        `OFS_BAL_SLOW_STEPS: var_rdata_o <= bal_slow_s_r;
        `OFS_BAL_QUICK_WEIGHT: var_rdata_o <= bal_quick_w_r;
        `OFS_BAL_QUICK_STEPS: var_rdata_o <= bal_quick_s_r;
        `OFS_FRAME_TIMEOUT: var_rdata_o <= timeout_r;
        `OFS_STROBE_LIMIT: var_rdata_o <= strobe_lim_r;
        `OFS_DAYLIGHT_LIMIT: var_rdata_o <= day_lim_r;
        `OFS_DIM_OPTIONS: var_rdata_o <= dim_opt_r;
        `OFS_DIM_GAIN_LOWER: var_rdata_o <= gain_lo_r;
        `OFS_DIM_GAIN_UPPER: var_rdata_o <= gain_hi_r;
        `OFS_SAT_UPPER: var_rdata_o <= sat_hi_r;
        `OFS_SAT_LOWER: var_rdata_o <= sat_lo_r;
        `OFS_INTERP_LOWER: var_rdata_o <= interp_lo_r;
        `OFS_INTERP_UPPER: var_rdata_o <= interp_hi_r;
        default: var_rdata_o <= 8'h00;
      endcase
    end
  end

endmodule

/* File: camera_mode_sequencer_consts.vh */
// constants of the camera mode sequencer: variable offsets, reset values, codes
// assumes byte-wide variable access with byte offsets as printed
`ifndef CAMERA_MODE_SEQUENCER_CONSTS_VH
`define CAMERA_MODE_SEQUENCER_CONSTS_VH

// variable offsets
`define OFS_METHOD_PTR_HI 5'h00
`define OFS_METHOD_PTR_LO 5'h01
`define OFS_DRIVER_ENABLE 5'h02
`define OFS_PROGRAM_REQ 5'h03
`define OFS_CURRENT_PHASE 5'h04
`define OFS_STEP_CTRL 5'h05
`define OFS_STROBE_KIND 5'h06
`define OFS_EXP_SLOW_WEIGHT 5'h07
`define OFS_EXP_SLOW_STEPS 5'h08
`define OFS_EXP_QUICK_WEIGHT 5'h09
`define OFS_EXP_QUICK_STEPS 5'h0A
`define OFS_BAL_SLOW_WEIGHT 5'h0B
`define OFS_BAL_SLOW_STEPS 5'h0C
`define OFS_BAL_QUICK_WEIGHT 5'h0D
`define OFS_BAL_QUICK_STEPS 5'h0E
`define OFS_FRAME_TIMEOUT 5'h12
`define OFS_STROBE_LIMIT 5'h13
`define OFS_DAYLIGHT_LIMIT 5'h14
`define OFS_DIM_OPTIONS 5'h15
`define OFS_DIM_GAIN_LOWER 5'h16
`define OFS_DIM_GAIN_UPPER 5'h17
`define OFS_SAT_UPPER 5'h18
`define OFS_SAT_LOWER 5'h19
`define OFS_INTERP_LOWER 5'h1A
`define OFS_INTERP_UPPER 5'h1B

// reset values
`define RST_METHOD_PTR 16'hF06B
`define RST_DRIVER_ENABLE 8'h0F
`define RST_PROGRAM_REQ 8'h00
`define RST_STEP_CTRL 8'h00
`define RST_STROBE_KIND 8'h00
`define RST_SLOW_WEIGHT 8'h08
`define RST_SLOW_STEPS 8'h02
`define RST_QUICK_WEIGHT 8'h20
`define RST_QUICK_STEPS 8'h01
`define RST_FRAME_TIMEOUT 8'h1E
`define RST_STROBE_LIMIT 8'h00
`define RST_DAYLIGHT_LIMIT 8'h0A
`define RST_DIM_OPTIONS 8'h60
`define RST_DIM_GAIN_LOWER 8'h51
`define RST_DIM_GAIN_UPPER 8'h5A
`define RST_SAT_UPPER 8'h80
`define RST_SAT_LOWER 8'h00
`define RST_INTERP_LOWER 8'h10
`define RST_INTERP_UPPER 8'h40

// weight value that turns averaging off
`define WEIGHT_NO_AVERAGE 8'h20

// program codes
`define PRG_RUN 8'h00
`define PRG_PREVIEW 8'h01
`define PRG_CAPTURE 8'h02
`define PRG_STANDBY 8'h03
`define PRG_LOCK 8'h04
`define PRG_REFRESH 8'h05
`define PRG_REFRESH_MODE 8'h06

// phase codes
`define PH_INIT 4'h0
`define PH_TO_PREVIEW 4'h1
`define PH_ENTER_PREVIEW 4'h2
`define PH_PREVIEW 4'h3
`define PH_LEAVE_PREVIEW 4'h4
`define PH_TO_CAPTURE 4'h5
`define PH_ENTER_CAPTURE 4'h6
`define PH_CAPTURE 4'h7
`define PH_LEAVE_CAPTURE 4'h8
`define PH_STANDBY 4'h9

// field positions
`define STEP_ON_BIT 0
`define STEP_GO_BIT 1
`define STROBE_LOCK_BIT 7
`define OUTDOOR_BIT 5
`define DIM_INTERP_BIT 0
`define DIM_SAT_BIT 1
`define DIM_APCORR_BIT 2
`define DIM_APTHRESH_BIT 3
`define DIM_YFILT_BIT 4

// flash modes of the current phase
`define FLASH_OFF 2'h0
`define FLASH_ON 2'h1
`define FLASH_LOCKED 2'h2
`define FLASH_AUTO 2'h3

`endif

/* File: camera_mode_sequencer_checker.sv */
// port checker for the camera mode sequencer
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/100ps
`include "camera_mode_sequencer_consts.vh"
module camera_mode_sequencer_checker (
  // clock, reset and variable port
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire [4:0] var_addr_i,
  input wire var_wr_i,
  input wire [7:0] var_wdata_i,
  input wire [7:0] var_rdata_o,
  // measurements
  input wire [7:0] exposure_value_i,
  input wire [7:0] exposure_virtual_gain_i,
  input wire [7:0] digital_gain_one_i,
  input wire [7:0] digital_gain_two_i,
  // results
  input wire [4:0] driver_enable_o,
  input wire refresh_o,
  input wire [3:0] phase_o,
  input wire [7:0] exposure_weight_o,
  input wire exposure_average_o,
  input wire [7:0] balance_weight_o,
  input wire balance_average_o,
  input wire force_daylight_o,
  input wire flash_fire_o,
  input wire [1:0] flash_kind_o,
  input wire [9:0] virtual_gain_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_ENABLE: assert property (var_wr_i && var_addr_i == `OFS_DRIVER_ENABLE
    |-> ##2 driver_enable_o == $past(var_wdata_i[4:0], 2)) else $error("driver enable not updated");
  AST_PHASE_READ: assert property (var_addr_i == `OFS_CURRENT_PHASE
    |=> var_rdata_o == {4'h0, phase_o}) else $error("phase read differs from phase output");
  AST_PHASE_CODE: assert property (phase_o <= `PH_STANDBY) else $error("phase code out of range");
  AST_REFRESH: assert property (refresh_o |=> !refresh_o) else $error("refresh pulse too long");
  AST_KIND: assert property (var_wr_i && var_addr_i == `OFS_STROBE_KIND
    |-> ##2 flash_kind_o == $past(var_wdata_i[1:0], 2)) else $error("flash kind not updated");
  AST_EXP_AVG: assert property ($past(rst_n_i)
    |-> exposure_average_o == (exposure_weight_o < `WEIGHT_NO_AVERAGE)) else $error("exposure averaging wrong");
  AST_BAL_AVG: assert property ($past(rst_n_i)
    |-> balance_average_o == (balance_weight_o < `WEIGHT_NO_AVERAGE)) else $error("balance averaging wrong");
  AST_FIRE: assert property (flash_fire_o |-> flash_kind_o != 2'h0) else $error("flash fired with no flash");
  AST_DAYLIGHT: assert property ($past(exposure_value_i) == 8'h00
    |-> !force_daylight_o) else $error("daylight forced at zero exposure");
  AST_VGAIN: assert property ($past(rst_n_i) |-> virtual_gain_o == ($past(exposure_virtual_gain_i) >> 1)
    + ($past(digital_gain_one_i) >> 4) + ($past(digital_gain_two_i) >> 2)) else $error("virtual gain wrong");
endmodule

bind camera_mode_sequencer camera_mode_sequencer_checker u_camera_mode_sequencer_checker (
  .sys_clk_i, .rst_n_i, .var_addr_i, .var_wr_i, .var_wdata_i, .var_rdata_o, .exposure_value_i,
  .exposure_virtual_gain_i, .digital_gain_one_i, .digital_gain_two_i, .driver_enable_o, .refresh_o,
  .phase_o, .exposure_weight_o, .exposure_average_o, .balance_weight_o, .balance_average_o,
  .force_daylight_o, .flash_fire_o, .flash_kind_o, .virtual_gain_o);

/* File: camera_mode_sequencer_bench.sv */
// self-checking bench for the camera mode sequencer
// assumes the constants header is on the include path
`timescale 1ns/100ps
`include "camera_mode_sequencer_consts.vh"
module camera_mode_sequencer_bench;
  reg sys_clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [4:0] var_addr_i = 5'h00;
  reg var_wr_i = 1'b0;
  reg [7:0] var_wdata_i = 8'h00;
  reg frame_start_i = 1'b0;
  reg drivers_settled_i = 1'b1;
  reg exposure_fast_i = 1'b0;
  reg balance_fast_i = 1'b0;
  reg [1:0] flash_mode_i = 2'h0;
  reg [7:0] exposure_value_i = 8'h00;
  reg [7:0] exposure_virtual_gain_i = 8'h00;
  reg [7:0] digital_gain_one_i = 8'h00;
  reg [7:0] digital_gain_two_i = 8'h00;
  wire [7:0] var_rdata_o, exposure_weight_o, exposure_steps_o, balance_weight_o, balance_steps_o;
  wire [7:0] saturation_o, interp_threshold_o;
  wire [4:0] driver_enable_o;
  wire [3:0] phase_o;
  wire [1:0] flash_kind_o;
  wire [9:0] virtual_gain_o;
  wire driver_timeout_o, refresh_o, exposure_average_o, balance_average_o, force_daylight_o, flash_fire_o;
  wire reduce_aperture_o, raise_aperture_thresh_o, luma_filter_o;
  integer num_errors = 0;
  integer num_checks = 0;
  integer refresh_seen = 0;

  camera_mode_sequencer u_camera_mode_sequencer (
    .sys_clk_i, .rst_n_i, .var_addr_i, .var_wr_i, .var_wdata_i, .var_rdata_o, .frame_start_i,
    .drivers_settled_i, .exposure_fast_i, .balance_fast_i, .flash_mode_i, .exposure_value_i,
    .exposure_virtual_gain_i, .digital_gain_one_i, .digital_gain_two_i, .driver_enable_o,
    .driver_timeout_o, .refresh_o, .phase_o, .exposure_weight_o, .exposure_steps_o, .exposure_average_o,
    .balance_weight_o, .balance_steps_o, .balance_average_o, .force_daylight_o, .flash_fire_o,
    .flash_kind_o, .virtual_gain_o, .saturation_o, .interp_threshold_o, .reduce_aperture_o,
    .raise_aperture_thresh_o, .luma_filter_o);

  always #2.5 sys_clk_i = ~sys_clk_i;

  always @(negedge sys_clk_i) begin
    if (refresh_o === 1'b1)
      refresh_seen = refresh_seen + 1;
  end

  task check(input string what, input [9:0] seen, input [9:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  task cyc(input integer n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  task wr(input [4:0] a, input [7:0] d);
    begin
      var_addr_i = a;
      var_wdata_i = d;
      var_wr_i = 1'b1;
      cyc(1);
      var_wr_i = 1'b0;
      cyc(1);
    end
  endtask

  task rd(input [4:0] a, input [7:0] e);
    begin
      var_addr_i = a;
      cyc(1);
      check("rdata", var_rdata_o, e);
    end
  endtask

  // a program is taken one edge after its write lands
  task ph(input [7:0] e);
    begin
      cyc(2);
      rd(`OFS_CURRENT_PHASE, e);
    end
  endtask

  task frame;
    begin
      frame_start_i = 1'b1;
      cyc(1);
      frame_start_i = 1'b0;
      cyc(2);
    end
  endtask

  task t_reset;
    begin
      rd(`OFS_METHOD_PTR_HI, 8'hF0);
      rd(`OFS_METHOD_PTR_LO, 8'h6B);
      rd(`OFS_DRIVER_ENABLE, 8'h0F);
      rd(`OFS_CURRENT_PHASE, 8'h03);
      rd(`OFS_FRAME_TIMEOUT, 8'h1E);
      rd(`OFS_DIM_OPTIONS, 8'h60);
      rd(`OFS_INTERP_UPPER, 8'h40);
      rd(5'h10, 8'h00);
      check("phase_o", phase_o, 4'h3);
      check("sat", saturation_o, 8'h80);
      check("eweight", exposure_weight_o, 8'h08);
    end
  endtask

  task t_access;
    begin
      wr(`OFS_CURRENT_PHASE, 8'h07);
      rd(`OFS_CURRENT_PHASE, 8'h03);
      wr(5'h1C, 8'h55);
      rd(5'h1C, 8'h00);
      wr(`OFS_DRIVER_ENABLE, 8'h15);
      cyc(1);
      check("enable", driver_enable_o, 5'h15);
      wr(`OFS_DRIVER_ENABLE, 8'h2F);
      rd(`OFS_DRIVER_ENABLE, 8'h2F);
    end
  endtask

  task t_weights;
    begin
      exposure_fast_i = 1'b1;
      balance_fast_i = 1'b1;
      cyc(2);
      check("eweight", exposure_weight_o, 8'h20);
      check("esteps", exposure_steps_o, 8'h01);
      check("bsteps", balance_steps_o, 8'h01);
      check("bavg", balance_average_o, 1'b0);
      wr(`OFS_BAL_QUICK_WEIGHT, 8'h1F);
      cyc(2);
      check("bavg", balance_average_o, 1'b1);
      check("bweight", balance_weight_o, 8'h1F);
      exposure_fast_i = 1'b0;
      balance_fast_i = 1'b0;
      wr(`OFS_EXP_SLOW_STEPS, 8'h05);
      cyc(2);
      check("esteps", exposure_steps_o, 8'h05);
      check("eavg", exposure_average_o, 1'b1);
      check("bsteps", balance_steps_o, 8'h02);
    end
  endtask

  task t_programs;
    begin
      wr(`OFS_PROGRAM_REQ, `PRG_RUN);
      wr(`OFS_PROGRAM_REQ, `PRG_PREVIEW);
      ph(8'h03);
      rd(`OFS_PROGRAM_REQ, 8'h00);
      wr(`OFS_PROGRAM_REQ, `PRG_REFRESH);
      ph(8'h03);
      check("refresh", refresh_seen, 1);
      flash_mode_i = 2'h1;
      wr(`OFS_STROBE_KIND, 8'h02);
      wr(`OFS_PROGRAM_REQ, `PRG_LOCK);
      ph(8'h03);
      rd(`OFS_STROBE_KIND, 8'h82);
      flash_mode_i = 2'h0;
      wr(`OFS_PROGRAM_REQ, `PRG_CAPTURE);
      ph(8'h04);
      wr(`OFS_STEP_CTRL, 8'h01);
      frame;
      rd(`OFS_CURRENT_PHASE, 8'h04);
      wr(`OFS_STEP_CTRL, 8'h03);
      ph(8'h05);
      rd(`OFS_STEP_CTRL, 8'h01);
      wr(`OFS_STEP_CTRL, 8'h00);
      frame;
      frame;
      rd(`OFS_CURRENT_PHASE, 8'h07);
      wr(`OFS_PROGRAM_REQ, `PRG_STANDBY);
      ph(8'h08);
      frame;
      rd(`OFS_CURRENT_PHASE, 8'h09);
      wr(`OFS_PROGRAM_REQ, `PRG_REFRESH_MODE);
      ph(8'h01);
      frame;
      frame;
      rd(`OFS_CURRENT_PHASE, 8'h03);
    end
  endtask

  // settled held low so only the frame limit can move the phase on
  task t_timeout;
    begin
      drivers_settled_i = 1'b0;
      wr(`OFS_FRAME_TIMEOUT, 8'h02);
      wr(`OFS_PROGRAM_REQ, `PRG_STANDBY);
      ph(8'h04);
      frame;
      check("timeout", driver_timeout_o, 1'b0);
      rd(`OFS_CURRENT_PHASE, 8'h04);
      frame;
      check("timeout", driver_timeout_o, 1'b1);
      frame;
      rd(`OFS_CURRENT_PHASE, 8'h09);
      drivers_settled_i = 1'b1;
      wr(`OFS_PROGRAM_REQ, `PRG_REFRESH_MODE);
      cyc(2);
      frame;
      frame;
    end
  endtask

  task t_lowlight;
    begin
      wr(`OFS_DIM_OPTIONS, 8'h1F);
      exposure_virtual_gain_i = 8'hB4;
      digital_gain_one_i = 8'h1F;
      digital_gain_two_i = 8'h07;
      cyc(3);
      check("vgain", virtual_gain_o, 10'h05C);
      check("sat", saturation_o, 8'h00);
      check("interp", interp_threshold_o, 8'h40);
      check("aperture", {reduce_aperture_o, raise_aperture_thresh_o, luma_filter_o}, 3'h7);
      exposure_virtual_gain_i = 8'hA3;
      digital_gain_one_i = 8'h0F;
      digital_gain_two_i = 8'h03;
      cyc(3);
      check("vgain", virtual_gain_o, 10'h051);
      check("sat", saturation_o, 8'h80);
      check("interp", interp_threshold_o, 8'h10);
      exposure_value_i = 8'h0B;
      cyc(2);
      check("daylight", force_daylight_o, 1'b1);
      flash_mode_i = 2'h3;
      wr(`OFS_STROBE_LIMIT, 8'h0B);
      exposure_value_i = 8'h0A;
      cyc(2);
      check("daylight", force_daylight_o, 1'b0);
      check("fire", flash_fire_o, 1'b1);
      exposure_value_i = 8'h0B;
      cyc(2);
      check("fire", flash_fire_o, 1'b0);
      flash_mode_i = 2'h2;
      cyc(2);
      check("fire", flash_fire_o, 1'b1);
    end
  endtask

  task results;
    begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  initial begin
    cyc(8);
    rst_n_i = 1'b1;
    cyc(2);
    t_reset;
    t_access;
    t_weights;
    t_programs;
    t_timeout;
    t_lowlight;
    results;
  end

  // the whole run needs some 150 cycles; allow over twenty times that
  initial begin
    #20000;
    num_errors = num_errors + 1;
    results;
  end
endmodule
